// ===== two_wire_params.svh
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

// register byte offsets on the axi4-lite bus
`define OFS_SERIAL_CONTROL 8'h00
`define OFS_SERIAL_STATUS 8'h04
`define OFS_SERIAL_DATA 8'h08
`define OFS_OWN_ADDRESS 8'h0c

// serial_control field positions
`define CTL_IRQ_FLAG 7
`define CTL_ACK_ENABLE 6
`define CTL_START_REQUEST 5
`define CTL_STOP_REQUEST 4
`define CTL_WRITE_COLLISION 3
`define CTL_SERIAL_ENABLE 2
`define CTL_IRQ_ENABLE 0

// reset values
`define RST_OWN_ADDRESS 8'h00
`define RST_SERIAL_DATA 8'hff
`define RST_PRESCALER 2'h0

// status codes, prescaler bits zero
`define ST_OWN_WRITE_ACK 8'h60
`define ST_ARB_OWN_WRITE_ACK 8'h68
`define ST_GEN_CALL_ACK 8'h70
`define ST_ARB_GEN_CALL_ACK 8'h78
`define ST_OWN_DATA_ACK 8'h80
`define ST_OWN_DATA_NACK 8'h88
`define ST_GEN_DATA_ACK 8'h90
`define ST_GEN_DATA_NACK 8'h98
`define ST_NO_INFO 8'hf8

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// bit counter terminal value within a byte
`define LAST_BIT 3'h7

`endif

// ===== two_wire_pkg.sv
package two_wire_pkg;

   // slave receiver bus sequencer
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_addr_dec,
      st_addr_ack,
      st_data,
      st_data_dec,
      st_data_ack,
      st_hold
   } rx_state_t;

   // register select from the bus address
   typedef enum logic [2:0] {
      sel_control,
      sel_status,
      sel_data,
      sel_address,
      sel_none
   } reg_sel_t;

endpackage

// ===== line_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for the scl and sda pins, idle high
module line_sync (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [1:0] line_in,
   output logic [1:0] line_out
);

   logic [1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_reg <= 2'h3;
         line_out <= 2'h3;
      end else begin
         meta_reg <= line_in;
         line_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ===== two_wire_slave_receiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_params.svh"

module two_wire_slave_receiver
   import two_wire_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic sleep_active,
   input wire logic arb_lost,
   output logic wake_request
);

   // register address decode, shared by read and write paths
   function automatic reg_sel_t decode(input logic [7:0] addr);
      reg_sel_t sel;
      sel = sel_none;
      unique case (addr)
         `OFS_SERIAL_CONTROL: sel = sel_control;
         `OFS_SERIAL_STATUS: sel = sel_status;
         `OFS_SERIAL_DATA: sel = sel_data;
         `OFS_OWN_ADDRESS: sel = sel_address;
         default: sel = sel_none;
      endcase
      return sel;
   endfunction

   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic aw_full_next;
   logic w_full_next;
   logic rvalid_next;
   logic wr_fire;
   logic rd_fire;
   reg_sel_t wr_sel;
   logic lane0;

   logic irq_flag_reg;
   logic ack_enable_reg;
   logic start_request_reg;
   logic stop_request_reg;
   logic write_collision_reg;
   logic serial_enable_reg;
   logic irq_enable_reg;
   logic [7:0] status_reg;
   logic [1:0] prescaler_reg;
   logic [7:0] data_reg;
   logic [7:0] own_address_reg;

   logic [1:0] line_sync_out;
   logic scl_s;
   logic sda_s;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   rx_state_t state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic gen_call_reg;
   logic ack_hold_reg;
   logic leave_reg;
   logic arb_pend_reg;
   logic sw_clear;
   logic addr_match;
   logic irq_set;
   logic [7:0] irq_code;

   // axi write channel handshakes; address and data taken in either order
   assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign aw_full_next = (aw_full_reg | (s_axi_awvalid & s_axi_awready)) & ~wr_fire;
   assign w_full_next = (w_full_reg | (s_axi_wvalid & s_axi_wready)) & ~wr_fire;
   assign wr_sel = decode(aw_addr_reg);
   assign lane0 = wr_fire & w_strb_reg[0];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         s_axi_awready <= ~aw_full_next;
         s_axi_wready <= ~w_full_next;
      end
   end

   // write response, unmapped offsets answer slverr
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == sel_none) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: one outstanding read, data one cycle after address
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign rvalid_next = (s_axi_rvalid & ~s_axi_rready) | rd_fire;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_next;
         s_axi_rvalid <= rvalid_next;
         if (rd_fire) begin
            s_axi_rresp <= `RESP_OKAY;
            unique case (decode(s_axi_araddr))
               sel_control: s_axi_rdata <= {24'h000000, irq_flag_reg, ack_enable_reg,
                  start_request_reg, stop_request_reg, write_collision_reg,
                  serial_enable_reg, 1'b0, irq_enable_reg};
               sel_status: s_axi_rdata <= {24'h000000, status_reg[7:3], 1'b0, prescaler_reg};
               sel_data: s_axi_rdata <= {24'h000000, data_reg};
               sel_address: s_axi_rdata <= {24'h000000, own_address_reg};
               sel_none: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // writing one to the flag bit clears it
   assign sw_clear = lane0 & (wr_sel == sel_control) & w_data_reg[`CTL_IRQ_FLAG];

   // control bits written by software
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_enable_reg <= 1'b0;
         start_request_reg <= 1'b0;
         stop_request_reg <= 1'b0;
         serial_enable_reg <= 1'b0;
         irq_enable_reg <= 1'b0;
         prescaler_reg <= `RST_PRESCALER;
         own_address_reg <= `RST_OWN_ADDRESS;
      end else if (lane0) begin
         if (wr_sel == sel_control) begin
            ack_enable_reg <= w_data_reg[`CTL_ACK_ENABLE];
            start_request_reg <= w_data_reg[`CTL_START_REQUEST];
            stop_request_reg <= w_data_reg[`CTL_STOP_REQUEST];
            serial_enable_reg <= w_data_reg[`CTL_SERIAL_ENABLE];
            irq_enable_reg <= w_data_reg[`CTL_IRQ_ENABLE];
         end
         if (wr_sel == sel_status) begin
            prescaler_reg <= w_data_reg[1:0];
         end
         if (wr_sel == sel_address) begin
            own_address_reg <= w_data_reg[7:0];
         end
      end
   end

   // interrupt flag; a hardware set beats a software clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_flag_reg <= 1'b0;
      end else if (irq_set) begin
         irq_flag_reg <= 1'b1;
      end else if (sw_clear) begin
         irq_flag_reg <= 1'b0;
      end
   end

   // status code follows each flag event, no-info once released
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status_reg <= `ST_NO_INFO;
      end else if (irq_set) begin
         status_reg <= irq_code;
      end else if (sw_clear) begin
         status_reg <= `ST_NO_INFO;
      end
   end

   // data register; collision when written while the flag is low
   // only data bytes land here, so an address match in sleep leaves it stale
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         data_reg <= `RST_SERIAL_DATA;
         write_collision_reg <= 1'b0;
      end else if (state_reg == st_data_dec && scl_fall && !start_det && !stop_det) begin
         data_reg <= shift_reg;
      end else if (lane0 && wr_sel == sel_data) begin
         if (irq_flag_reg) begin
            data_reg <= w_data_reg[7:0];
            write_collision_reg <= 1'b0;
         end else begin
            write_collision_reg <= 1'b1;
         end
      end
   end

   // pin sampling and edge detection
   line_sync u_line_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .line_in({scl_i, sda_i}),
      .line_out(line_sync_out)
   );

   assign scl_s = line_sync_out[1];
   assign sda_s = line_sync_out[0];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // own address with write bit, or general call when enabled
   assign addr_match = ~shift_reg[0] &
      ((shift_reg[7:1] == own_address_reg[7:1]) ||
       (shift_reg[7:1] == 7'h00 && own_address_reg[0]));

   // flag events at the falling edge closing each acknowledge bit
   assign irq_set = serial_enable_reg & scl_fall & ~start_det & ~stop_det &
      (state_reg == st_addr_ack || state_reg == st_data_ack);

   always_comb begin
      irq_code = `ST_NO_INFO;
      if (state_reg == st_addr_ack) begin
         if (gen_call_reg) begin
            irq_code = arb_pend_reg ? `ST_ARB_GEN_CALL_ACK : `ST_GEN_CALL_ACK;
         end else begin
            irq_code = arb_pend_reg ? `ST_ARB_OWN_WRITE_ACK : `ST_OWN_WRITE_ACK;
         end
      end else if (gen_call_reg) begin
         irq_code = ack_hold_reg ? `ST_GEN_DATA_ACK : `ST_GEN_DATA_NACK;
      end else begin
         irq_code = ack_hold_reg ? `ST_OWN_DATA_ACK : `ST_OWN_DATA_NACK;
      end
   end

   // arbitration loss from the master side is remembered until the next flag event or a stop
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arb_pend_reg <= 1'b0;
      end else if (arb_lost) begin
         arb_pend_reg <= 1'b1;
      end else if (irq_set || stop_det) begin
         arb_pend_reg <= 1'b0;
      end
   end

   // ack choice for data bytes follows the enable written with the clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_hold_reg <= 1'b0;
      end else if (sw_clear) begin
         ack_hold_reg <= w_data_reg[`CTL_ACK_ENABLE];
      end
   end

   // wake request from an address match taken while asleep
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wake_request <= 1'b0;
      end else if (irq_set && state_reg == st_addr_ack && sleep_active) begin
         wake_request <= 1'b1;
      end else if (sw_clear) begin
         wake_request <= 1'b0;
      end
   end

   // open-drain pins only ever pull low
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   // receive sequencer; start or stop on the bus overrides any state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= st_idle;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         gen_call_reg <= 1'b0;
         leave_reg <= 1'b0;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
      end else if (!serial_enable_reg) begin
         state_reg <= st_idle;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
      end else if (start_det) begin
         state_reg <= st_addr;
         bit_cnt_reg <= 3'h0;
         sda_oe <= 1'b0;
      end else if (stop_det) begin
         state_reg <= st_idle;
         sda_oe <= 1'b0;
      end else begin
         unique case (state_reg)
            st_idle: begin
               bit_cnt_reg <= 3'h0;
            end
            st_addr, st_data: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == `LAST_BIT) begin
                     state_reg <= (state_reg == st_addr) ? st_addr_dec : st_data_dec;
                  end
               end
            end
            st_addr_dec: begin
               // bus stays monitored; a refused address just waits out the frame
               if (scl_fall) begin
                  if (addr_match && ack_enable_reg) begin
                     sda_oe <= 1'b1;
                     gen_call_reg <= (shift_reg[7:1] == 7'h00);
                     state_reg <= st_addr_ack;
                  end else begin
                     state_reg <= st_idle;
                  end
               end
            end
            st_data_dec: begin
               if (scl_fall) begin
                  sda_oe <= ack_hold_reg;
                  leave_reg <= ~ack_hold_reg;
                  state_reg <= st_data_ack;
               end
            end
            st_addr_ack, st_data_ack: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  scl_oe <= 1'b1;
                  if (state_reg == st_addr_ack) begin
                     leave_reg <= 1'b0;
                  end
                  state_reg <= st_hold;
               end
            end
            st_hold: begin
               // clock held low until software clears the flag
               if (!irq_flag_reg) begin
                  scl_oe <= 1'b0;
                  bit_cnt_reg <= 3'h0;
                  state_reg <= leave_reg ? st_idle : st_data;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== two_wire_sva.sv
`timescale 1ns/1ps
`default_nettype none

// port-level checks on the slave receiver
module two_wire_sva (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic sleep_active,
   input wire logic wake_request
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // open drain: a released line is pulled to 1, never driven high
   a_open_drain: assert property (!scl_o && !sda_o) else $error("pin driven high");
   a_wake_holds_scl: assert property (wake_request |-> scl_oe) else $error("wake without hold");
   a_wake_asleep: assert property ($rose(wake_request) |-> $past(sleep_active))
      else $error("wake while awake");
   // sda may only move while scl is low, or the master sees a start or stop
   a_ack_scl_low: assert property ($changed(sda_oe) |-> $past(!scl_i))
      else $error("sda moved while scl high");
   a_no_ack_stretch: assert property (!(sda_oe && scl_oe)) else $error("ack during stretch");
   a_stretch_on_low: assert property ($rose(scl_oe) |-> $past(!scl_i))
      else $error("stretch began with scl high");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write answer late");

   c_wake: cover property ($rose(wake_request));
   c_stretch: cover property ($rose(scl_oe));
   c_ack: cover property ($rose(sda_oe));
endmodule

`default_nettype wire

// ===== bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// master transmitter on the two wires; scl only toggles inside frames
module bus_master_model (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // start: sda falls while scl is high
   task automatic do_start();
      #40 sda_low = 1'b1;
      #40 scl_low = 1'b1;
      #20;
   endtask

   // one clock pulse; waits out any stretch by the slave
   task automatic pulse(output logic ack);
      #20 scl_low = 1'b0;
      wait (scl_i);
      #20 ack = !sda_i;
      #20 scl_low = 1'b1;
      #20;
   endtask

   // byte msb first, then the ninth clock with sda released
   task automatic do_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = !b[i];
         pulse(ack);
      end
      sda_low = 1'b0;
      pulse(ack);
   endtask

   // stop: sda rises while scl is high, then both stay released
   task automatic do_stop();
      sda_low = 1'b1;
      #20 scl_low = 1'b0;
      wait (scl_i);
      #40 sda_low = 1'b0;
      #40;
   endtask
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_params.svh"

module testbench;
   localparam logic [6:0] own_addr = 7'h2a;
   localparam logic [6:0] other_addr = 7'h15;
   logic clk_sys, reset;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic scl_o, scl_oe, sda_o, sda_oe, sleep_active, arb_lost, wake_request;
   logic scl_low, sda_low, scl_w, sda_w;
   logic [1:0] wresp;
   int n_fail, checks, cycles;

   // wired-and lines with pull-ups
   assign scl_w = !(scl_low | scl_oe);
   assign sda_w = !(sda_low | sda_oe);

   two_wire_slave_receiver i_two_wire_slave_receiver (
      .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o,
      .sda_oe, .sleep_active, .arb_lost, .wake_request);

   bus_master_model i_bus_master_model (.scl_i(scl_w), .sda_i(sda_w), .scl_low, .sda_low);

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // hang guard, well above the expected run length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // write: address and data offered together, bready held until bvalid
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic ctl(input logic [7:0] v);
      logic [1:0] r;
      axi_write(`OFS_SERIAL_CONTROL, {24'h0, v}, r);
   endtask

   // prescaler bits masked off before comparing the code
   task automatic expect_status(input logic [7:0] exp, input string msg);
      logic [31:0] d;
      logic [1:0] r;
      repeat (8) @(posedge clk_sys);
      axi_read(`OFS_SERIAL_STATUS, d, r);
      chk(d & 32'hf8, {24'h0, exp}, msg);
   endtask

   task automatic send(input logic [7:0] b, input logic exp, input string msg);
      logic a;
      i_bus_master_model.do_byte(b, a);
      chk({31'h0, a}, {31'h0, exp}, msg);
   endtask

   task automatic sc_registers();
      logic [31:0] d;
      logic [1:0] r;
      axi_read(`OFS_SERIAL_STATUS, d, r);
      chk(d, {24'h0, `ST_NO_INFO}, "status idle");
      axi_read(`OFS_SERIAL_DATA, d, r);
      chk(d, {24'h0, `RST_SERIAL_DATA}, "data reset");
      axi_read(8'h10, d, r);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped read");
      axi_write(8'h10, 32'h55, r);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped write");
      axi_write(`OFS_OWN_ADDRESS, {24'h0, own_addr, 1'b1}, r);
      axi_read(`OFS_OWN_ADDRESS, d, r);
      chk(d, {24'h0, own_addr, 1'b1}, "own address");
   endtask

   task automatic sc_data_flow();
      logic [31:0] d;
      logic [1:0] r;
      ctl(8'h44);
      i_bus_master_model.do_start();
      send({own_addr, 1'b0}, 1'b1, "own address ack");
      expect_status(`ST_OWN_WRITE_ACK, "own write");
      axi_read(`OFS_SERIAL_CONTROL, d, r);
      chk(d & 32'h80, 32'h80, "flag set");
      ctl(8'hc4);
      send(8'ha5, 1'b1, "data ack");
      expect_status(`ST_OWN_DATA_ACK, "data acked");
      axi_read(`OFS_SERIAL_DATA, d, r);
      chk(d, 32'ha5, "data byte");
      ctl(8'h84);
      ctl(8'h44); // late ack enable must not count for this byte
      send(8'h3c, 1'b0, "data nack");
      expect_status(`ST_OWN_DATA_NACK, "data nacked");
      ctl(8'hc4);
      send(8'h11, 1'b0, "not addressed");
      i_bus_master_model.do_stop();
   endtask

   task automatic addr_case(input logic [7:0] c, input logic arb, input logic [7:0] ab,
         input logic exp, input logic [7:0] st);
      ctl(c);
      if (arb) begin
         @(posedge clk_sys);
         arb_lost <= 1'b1;
         @(posedge clk_sys);
         arb_lost <= 1'b0;
      end
      i_bus_master_model.do_start();
      send(ab, exp, "address ack");
      expect_status(st, "address status");
      if (exp) ctl(8'hc4);
      if (exp && ab == 8'h00) begin
         send(8'h5a, 1'b1, "general data ack");
         expect_status(`ST_GEN_DATA_ACK, "general data");
         ctl(8'h84);
      end
      i_bus_master_model.do_stop();
   endtask

   // long wake-up: scl stays low until software clears the flag
   task automatic sc_sleep();
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk_sys);
      sleep_active <= 1'b1;
      i_bus_master_model.do_start();
      send({own_addr, 1'b0}, 1'b1, "sleep address ack");
      repeat (40) @(posedge clk_sys);
      chk({30'h0, wake_request, scl_oe}, 32'h3, "wake and hold");
      ctl(8'hc4);
      repeat (4) @(posedge clk_sys);
      chk({30'h0, wake_request, scl_oe}, 32'h0, "released");
      axi_read(`OFS_SERIAL_DATA, d, r);
      chk(d, 32'h5a, "data kept on wake");
      sleep_active <= 1'b0;
      i_bus_master_model.do_stop();
   endtask

   initial begin
      reset = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {sleep_active, arb_lost} = '0;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      sc_registers();
      sc_data_flow();
      addr_case(8'h04, 1'b0, {own_addr, 1'b0}, 1'b0, `ST_NO_INFO);
      addr_case(8'h44, 1'b0, {own_addr, 1'b0}, 1'b1, `ST_OWN_WRITE_ACK);
      addr_case(8'h44, 1'b0, {own_addr, 1'b1}, 1'b0, `ST_NO_INFO);
      addr_case(8'h44, 1'b0, {other_addr, 1'b0}, 1'b0, `ST_NO_INFO);
      addr_case(8'h44, 1'b0, 8'h00, 1'b1, `ST_GEN_CALL_ACK);
      addr_case(8'h44, 1'b1, {own_addr, 1'b0}, 1'b1, `ST_ARB_OWN_WRITE_ACK);
      addr_case(8'h44, 1'b1, 8'h00, 1'b1, `ST_ARB_GEN_CALL_ACK);
      ctl(8'h44);
      axi_write(`OFS_OWN_ADDRESS, {24'h0, own_addr, 1'b0}, wresp);
      chk({30'h0, wresp}, {30'h0, `RESP_OKAY}, "address write");
      addr_case(8'h44, 1'b0, 8'h00, 1'b0, `ST_NO_INFO);
      sc_sleep();
      print_verdict();
   end
endmodule

bind two_wire_slave_receiver two_wire_sva i_two_wire_sva (
   .clk_sys, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .sleep_active,
   .wake_request);

`default_nettype wire
